// [shared/ccd_consts.svh]
// Constants for the codec coefficient, debounce and readback command block.
// Assumes a single 200 MHz core clock; included by bare name.
`ifndef CCD_CONSTS_SVH
`define CCD_CONSTS_SVH

// ----------------------------------------------------------------
// Command codes (even code = write, odd code = read)
// ----------------------------------------------------------------
`define CCD_CMD_FIR_Z 8'h98
`define CCD_CMD_IIR_Z 8'h9A
`define CCD_CMD_DEBOUNCE 8'hC8
`define CCD_CMD_XMT_READ 8'hCD
`define CCD_RW_BIT 0

// ----------------------------------------------------------------
// Data lengths in bytes
// ----------------------------------------------------------------
`define CCD_LEN_FIR 4'd10
`define CCD_LEN_IIR 4'd5
`define CCD_LEN_CFG 4'd1
`define CCD_LEN_XMT 4'd2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CCD_FIR_RST 80'h0190_0190_0190_0190_0190
`define CCD_IIR_RST 40'h01_9001_0190
`define CCD_CFG_RST 8'h20

// ----------------------------------------------------------------
// Configuration byte fields
// ----------------------------------------------------------------
`define CCD_CFG_STB_EN 7
`define CCD_CFG_STB_POL 6
`define CCD_CFG_DEB_HI 5
`define CCD_CFG_DEB_LO 2
`define CCD_CFG_DBL_CLK 1
`define CCD_CFG_CHOP_EN 0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CCD_CLK_KHZ 200000
`define CCD_SAMPLE_KHZ 32
`define CCD_SAMPLE_CYC (`CCD_CLK_KHZ / `CCD_SAMPLE_KHZ)
`define CCD_MS_TIME_US 1000
`define CCD_MS_CYC (`CCD_CLK_KHZ * `CCD_MS_TIME_US / 1000)
`define CCD_CHOP_KHZ 256
`define CCD_CHOP_HALF_CYC (`CCD_CLK_KHZ / (2 * `CCD_CHOP_KHZ))
`define CCD_HWY_BIT_KHZ 2048
`define CCD_HWY_HALF_CYC (`CCD_CLK_KHZ / (2 * `CCD_HWY_BIT_KHZ))

`endif

// [shared/ccd_pkg.sv]
// Types for the codec coefficient, debounce and readback command block.
// Assumes nothing beyond a SystemVerilog compiler.
package ccd_pkg;
	typedef enum logic [1:0] {
		CCD_ST_IDLE = 2'b00,
		CCD_ST_WRITE = 2'b01,
		CCD_ST_READ = 2'b10
	} ccd_state_e;

	typedef enum logic [1:0] {
		CCD_TGT_FIR = 2'b00,
		CCD_TGT_IIR = 2'b01,
		CCD_TGT_CFG = 2'b10,
		CCD_TGT_XMT = 2'b11
	} ccd_target_e;

	typedef logic signed [19:0] ccd_coef_t;
endpackage

// [shared/ccd_coef_if.sv]
// Carrier between the command engine and the Z filter datapath.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface ccd_coef_if;
	logic [79:0] fir;
	logic [39:0] iir;
	logic sample_tick;
	modport ctl (output fir, output iir, output sample_tick);
	modport filt (input fir, input iir, input sample_tick);
endinterface

// [rtl/ccd_zfilt.sv]
// Z filter datapath: five feed-forward taps plus first-order recursive term.
// Assumes coefficients and a one-cycle sample tick come over ccd_coef_if.
`timescale 1ns/1ps
module ccd_zfilt (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	ccd_coef_if.filt coef,
	input wire logic signed [15:0] sample_i,
	output logic signed [15:0] filt_out_o
);
	import ccd_pkg::*;

	localparam ccd_coef_t ONE = 20'sh1_0000;

	// ----------------------------------------------------------------
	// Coefficient decode
	// ----------------------------------------------------------------
	// One signed power-of-two step; a set sign bit negates
	function automatic ccd_coef_t term(input ccd_coef_t v, input logic [3:0] n);
		ccd_coef_t t;
		t = v >>> n[2:0];
		return n[3] ? -t : t;
	endfunction

	// Nested four-term product
	function automatic ccd_coef_t coef4(input logic [15:0] w);
		ccd_coef_t v;
		v = ONE + term(ONE, w[15:12]);
		v = ONE + term(v, w[11:8]);
		v = ONE + term(v, w[7:4]);
		return term(v, w[3:0]);
	endfunction

	ccd_coef_t zc [0:4];
	ccd_coef_t z5, z6, z7;
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			zc[i] = coef4(coef.fir[79 - 16 * i -: 16]);
		end
		z5 = coef4(coef.iir[39:24]);
		z6 = term(ONE + term(ONE, coef.iir[23:20]), coef.iir[19:16]);
		z7 = coef4(coef.iir[15:0]);
	end

	// ----------------------------------------------------------------
	// Filter state
	// ----------------------------------------------------------------
	logic signed [15:0] dly_reg [1:4];
	logic signed [15:0] dly_next [1:4];
	logic signed [23:0] rec_reg, rec_next;
	logic signed [15:0] out_reg, out_next;
	logic signed [35:0] prod;
	logic signed [43:0] prod_w;
	logic signed [27:0] acc;
	logic signed [23:0] drive;

	// Evaluate one output per sample tick; state only moves on the tick
	always_comb begin
		acc = 28'sd0;
		prod = zc[0] * sample_i;
		acc = acc + 28'(prod >>> 16);
		for (int i = 1; i < 5; i++) begin
			prod = zc[i] * dly_reg[i];
			acc = acc + 28'(prod >>> 16);
		end
		// Recursive input already carries the 1/z6 gain inside z5
		prod = z5 * dly_reg[1];
		drive = 24'(prod >>> 16);
		prod_w = z7 * (rec_reg + drive);
		rec_next = rec_reg;
		dly_next = dly_reg;
		out_next = out_reg;
		if (coef.sample_tick) begin
			rec_next = 24'(prod_w >>> 16);
			prod_w = z6 * rec_next;
			acc = acc + 28'(prod_w >>> 16);
			if (acc > 28'sd32767) begin
				out_next = 16'sh7FFF;
			end else if (acc < -28'sd32768) begin
				out_next = -16'sh8000;
			end else begin
				out_next = 16'(acc);
			end
			dly_next[1] = sample_i;
			for (int i = 2; i < 5; i++) begin
				dly_next[i] = dly_reg[i - 1];
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 1; i < 5; i++) begin
				dly_reg[i] <= 16'sh0000;
			end
			rec_reg <= 24'sh00_0000;
			out_reg <= 16'sh0000;
		end else begin
			dly_reg <= dly_next;
			rec_reg <= rec_next;
			out_reg <= out_next;
		end
	end

	assign filt_out_o = out_reg;
endmodule

// [rtl/ccd_top.sv]
// Command interpreter for Z filter coefficients, global debounce byte and
// transmit sample readback, plus strobe, chopper and highway clock outputs.
// Assumes byte-level framing of the serial control port is done outside;
// command bytes and data bytes arrive as one-cycle strobes on ref_clk_i.
//
// Behaviour
// - Command bit 0 selects write when 0 and read when 1.
// - FIR-only command moves ten bytes of five taps, recursive set untouched.
// - IIR-only command moves five bytes of z5, z6, z7, taps untouched.
// - Stored sign bit 0 means plus one, 1 means minus one.
// - z0-z5 and z7 are four-term nested products; z6 uses two terms.
// - Filter is five taps plus first-order recursion with z7 feedback.
// - Filter runs at a 32 kHz sample rate.
// - Reset loads 0190 into every coefficient word and 01 into z6.
// - Recursion input scaled by 1/z6, output multiplied by z6.
// - Debounce byte is global across all four channels.
// - Strobe enable bit turns strobe multiplexing on.
// - Strobe polarity 0 gives high-going pulse, 1 low-going.
// - No strobe output unless strobe mode select is 1.
// - Hook bit updates status only after stable for debounce milliseconds.
// - Debounce byte resets to 20 hex, eight milliseconds.
// - Double clock bit runs highway clock at twice the bit rate.
// - Chopper enable bit turns chopper clock on, off when 0.
// - Transmit readback accepted only in PCM-with-port mode, returns two bytes.
// - First byte is companded sample, or upper linear byte with sign bit 7.
// - Host writes reserved bits as 0; device may return anything there.
`timescale 1ns/1ps
`include "ccd_consts.svh"
module ccd_top #(
	parameter int SAMPLE_CYC = `CCD_SAMPLE_CYC,
	parameter int MS_CYC = `CCD_MS_CYC
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic cmd_valid_i,
	input wire logic data_valid_i,
	input wire logic [7:0] port_byte_i,
	input wire logic rd_req_i,
	output logic rd_valid_o,
	output logic [7:0] rd_data_o,
	input wire logic pcm_port_mode_i,
	input wire logic companded_mode_i,
	input wire logic [7:0] compressed_sample_i,
	input wire logic signed [15:0] linear_sample_i,
	input wire logic signed [15:0] zfilt_in_i,
	output logic signed [15:0] zfilt_out_o,
	input wire logic [3:0] hook_input_bit_i,
	output logic [3:0] hook_status_o,
	input wire logic strobe_mode_select_i,
	output logic strobe_output_o,
	output logic highway_clk_o,
	output logic chopper_clock_out_o
);
	import ccd_pkg::*;

	// ----------------------------------------------------------------
	// Command engine state
	// ----------------------------------------------------------------
	ccd_state_e state_reg, state_next;
	ccd_target_e tgt_reg, tgt_next;
	logic [3:0] idx_reg, idx_next;
	logic [3:0] len_reg, len_next;
	logic [79:0] buf_reg, buf_next;
	logic [79:0] fir_reg, fir_next;
	logic [39:0] iir_reg, iir_next;
	logic [7:0] cfg_reg, cfg_next;
	logic rd_valid_reg, rd_valid_next;
	logic [7:0] rd_data_reg, rd_data_next;
	logic [7:0] cmd_even;
	logic [7:0] xmt_byte;

	// First readback byte depends on the coding mode
	assign xmt_byte = companded_mode_i ? compressed_sample_i : linear_sample_i[15:8];
	assign cmd_even = {port_byte_i[7:1], 1'b0};

	// Decode commands, gather write bytes in a buffer, serve read bytes from it.
	// Writes land in the buffer first so an aborted frame never reaches the filter.
	always_comb begin
		state_next = state_reg;
		tgt_next = tgt_reg;
		idx_next = idx_reg;
		len_next = len_reg;
		buf_next = buf_reg;
		fir_next = fir_reg;
		iir_next = iir_reg;
		cfg_next = cfg_reg;
		rd_valid_next = 1'b0;
		rd_data_next = rd_data_reg;
		if (cmd_valid_i) begin
			state_next = CCD_ST_IDLE;
			idx_next = 4'd0;
			if (port_byte_i == `CCD_CMD_XMT_READ) begin
				if (pcm_port_mode_i) begin
					tgt_next = CCD_TGT_XMT;
					len_next = `CCD_LEN_XMT;
					buf_next = {xmt_byte, 8'h00, 64'h0};
					state_next = CCD_ST_READ;
				end
			end else if (cmd_even == `CCD_CMD_FIR_Z || cmd_even == `CCD_CMD_IIR_Z ||
				cmd_even == `CCD_CMD_DEBOUNCE) begin
				unique case (cmd_even)
					`CCD_CMD_FIR_Z: begin
						tgt_next = CCD_TGT_FIR;
						len_next = `CCD_LEN_FIR;
						buf_next = fir_reg;
					end
					`CCD_CMD_IIR_Z: begin
						tgt_next = CCD_TGT_IIR;
						len_next = `CCD_LEN_IIR;
						buf_next = {iir_reg, 40'h0};
					end
					default: begin
						tgt_next = CCD_TGT_CFG;
						len_next = `CCD_LEN_CFG;
						buf_next = {cfg_reg, 72'h0};
					end
				endcase
				state_next = port_byte_i[`CCD_RW_BIT] ? CCD_ST_READ : CCD_ST_WRITE;
			end
		end else begin
			unique case (state_reg)
				CCD_ST_IDLE: begin
					state_next = CCD_ST_IDLE;
				end
				CCD_ST_WRITE: begin
					if (data_valid_i) begin
						buf_next[8 * (9 - idx_reg) +: 8] = port_byte_i;
						idx_next = idx_reg + 4'd1;
						if (idx_reg == len_reg - 4'd1) begin
							// Commit the whole set at once
							state_next = CCD_ST_IDLE;
							unique case (tgt_reg)
								CCD_TGT_FIR: fir_next = buf_next;
								CCD_TGT_IIR: iir_next = buf_next[79:40];
								CCD_TGT_CFG: cfg_next = buf_next[79:72];
								CCD_TGT_XMT: cfg_next = cfg_reg;
							endcase
						end
					end
				end
				CCD_ST_READ: begin
					if (rd_req_i) begin
						rd_valid_next = 1'b1;
						rd_data_next = buf_reg[8 * (9 - idx_reg) +: 8];
						idx_next = idx_reg + 4'd1;
						if (idx_reg == len_reg - 4'd1) begin
							state_next = CCD_ST_IDLE;
						end
					end
				end
				default: begin
					state_next = CCD_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg <= CCD_ST_IDLE;
			tgt_reg <= CCD_TGT_FIR;
			idx_reg <= 4'd0;
			len_reg <= 4'd0;
			buf_reg <= 80'h0;
			fir_reg <= `CCD_FIR_RST;
			iir_reg <= `CCD_IIR_RST;
			cfg_reg <= `CCD_CFG_RST;
			rd_valid_reg <= 1'b0;
			rd_data_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			tgt_reg <= tgt_next;
			idx_reg <= idx_next;
			len_reg <= len_next;
			buf_reg <= buf_next;
			fir_reg <= fir_next;
			iir_reg <= iir_next;
			cfg_reg <= cfg_next;
			rd_valid_reg <= rd_valid_next;
			rd_data_reg <= rd_data_next;
		end
	end

	assign rd_valid_o = rd_valid_reg;
	assign rd_data_o = rd_data_reg;

	// ----------------------------------------------------------------
	// Sample and millisecond timebases
	// ----------------------------------------------------------------
	logic [15:0] smp_cnt_reg, smp_cnt_next;
	logic [17:0] ms_cnt_reg, ms_cnt_next;
	logic smp_tick_reg, smp_tick_next;
	logic ms_tick_reg, ms_tick_next;

	// Free-running dividers; ticks are one-cycle pulses
	always_comb begin
		smp_tick_next = (smp_cnt_reg == 16'(SAMPLE_CYC - 1));
		smp_cnt_next = smp_tick_next ? 16'h0000 : smp_cnt_reg + 16'h0001;
		ms_tick_next = (ms_cnt_reg == 18'(MS_CYC - 1));
		ms_cnt_next = ms_tick_next ? 18'h0_0000 : ms_cnt_reg + 18'h0_0001;
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			smp_cnt_reg <= 16'h0000;
			ms_cnt_reg <= 18'h0_0000;
			smp_tick_reg <= 1'b0;
			ms_tick_reg <= 1'b0;
		end else begin
			smp_cnt_reg <= smp_cnt_next;
			ms_cnt_reg <= ms_cnt_next;
			smp_tick_reg <= smp_tick_next;
			ms_tick_reg <= ms_tick_next;
		end
	end

	// ----------------------------------------------------------------
	// Z filter
	// ----------------------------------------------------------------
	ccd_coef_if coef_bus ();
	assign coef_bus.fir = fir_reg;
	assign coef_bus.iir = iir_reg;
	assign coef_bus.sample_tick = smp_tick_reg;

	ccd_zfilt u_zfilt (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.coef(coef_bus),
		.sample_i(zfilt_in_i),
		.filt_out_o(zfilt_out_o)
	);

	// ----------------------------------------------------------------
	// Hook-switch debounce, one counter per channel
	// ----------------------------------------------------------------
	logic [3:0] hook_debounce_ms;
	assign hook_debounce_ms = cfg_reg[`CCD_CFG_DEB_HI:`CCD_CFG_DEB_LO];

	for (genvar ch = 0; ch < 4; ch++) begin : g_hook
		logic [3:0] cnt_reg, cnt_next;
		logic st_reg, st_next;

		// Millisecond granularity: the first interval may be short by up to 1 ms
		always_comb begin
			cnt_next = 4'd0;
			st_next = st_reg;
			if (hook_input_bit_i[ch] != st_reg) begin
				if (cnt_reg >= hook_debounce_ms) begin
					st_next = hook_input_bit_i[ch];
				end else begin
					cnt_next = ms_tick_reg ? cnt_reg + 4'd1 : cnt_reg;
				end
			end
		end

		always_ff @(posedge ref_clk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				cnt_reg <= 4'd0;
				st_reg <= 1'b0;
			end else begin
				cnt_reg <= cnt_next;
				st_reg <= st_next;
			end
		end

		assign hook_status_o[ch] = st_reg;
	end

	// ----------------------------------------------------------------
	// Strobe, chopper and highway clock outputs
	// ----------------------------------------------------------------
	logic strobe_reg, strobe_next;
	logic chop_reg, chop_next;
	logic [8:0] chop_cnt_reg, chop_cnt_next;
	logic hwy_reg, hwy_next;
	logic [6:0] hwy_cnt_reg, hwy_cnt_next;
	logic [6:0] hwy_half;

	// Double mode halves the half-period of the highway clock
	assign hwy_half = cfg_reg[`CCD_CFG_DBL_CLK] ? 7'(`CCD_HWY_HALF_CYC / 2) : 7'(`CCD_HWY_HALF_CYC);

	always_comb begin
		// Strobe pulses once per sample; idle level follows polarity
		if (!strobe_mode_select_i) begin
			strobe_next = 1'b0;
		end else begin
			strobe_next = (cfg_reg[`CCD_CFG_STB_EN] & smp_tick_reg) ^ cfg_reg[`CCD_CFG_STB_POL];
		end
		chop_cnt_next = chop_cnt_reg + 9'd1;
		chop_next = chop_reg;
		if (!cfg_reg[`CCD_CFG_CHOP_EN]) begin
			chop_cnt_next = 9'd0;
			chop_next = 1'b0;
		end else if (chop_cnt_reg >= 9'(`CCD_CHOP_HALF_CYC - 1)) begin
			chop_cnt_next = 9'd0;
			chop_next = ~chop_reg;
		end
		hwy_cnt_next = hwy_cnt_reg + 7'd1;
		hwy_next = hwy_reg;
		if (hwy_cnt_reg >= hwy_half - 7'd1) begin
			hwy_cnt_next = 7'd0;
			hwy_next = ~hwy_reg;
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			strobe_reg <= 1'b0;
			chop_reg <= 1'b0;
			chop_cnt_reg <= 9'd0;
			hwy_reg <= 1'b0;
			hwy_cnt_reg <= 7'd0;
		end else begin
			strobe_reg <= strobe_next;
			chop_reg <= chop_next;
			chop_cnt_reg <= chop_cnt_next;
			hwy_reg <= hwy_next;
			hwy_cnt_reg <= hwy_cnt_next;
		end
	end

	assign strobe_output_o = strobe_reg;
	assign chopper_clock_out_o = chop_reg;
	assign highway_clk_o = hwy_reg;
endmodule

// [tb/ccd_checker.sv]
// Port-level checks for the command block, bound into ccd_top.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/1ps
module ccd_checker (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic cmd_valid_i,
	input wire logic data_valid_i,
	input wire logic [7:0] port_byte_i,
	input wire logic rd_req_i,
	input wire logic rd_valid_o,
	input wire logic [7:0] rd_data_o,
	input wire logic pcm_port_mode_i,
	input wire logic [3:0] hook_input_bit_i,
	input wire logic [3:0] hook_status_o,
	input wire logic strobe_mode_select_i,
	input wire logic strobe_output_o,
	input wire logic chopper_clock_out_o
);
	logic pend_reg, pend_next;
	logic [7:0] cfg_reg, cfg_next;

	// ----------------------------------------------------------------
	// Shadow of the configuration byte
	// ----------------------------------------------------------------
	// A new command drops a pending write, so a stray data byte never lands
	always_comb begin
		pend_next = pend_reg;
		cfg_next = cfg_reg;
		if (cmd_valid_i) begin
			pend_next = (port_byte_i == 8'hC8);
		end else if (data_valid_i && pend_reg) begin
			pend_next = 1'b0;
			cfg_next = port_byte_i;
		end
	end
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pend_reg <= 1'b0;
			cfg_reg <= 8'h20;
		end else begin
			pend_reg <= pend_next;
			cfg_reg <= cfg_next;
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking dcb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	sequence s_cfg_read;
		cmd_valid_i && port_byte_i == 8'hC9 ##[1:2] rd_req_i && !cmd_valid_i;
	endsequence
	sequence s_cd_refused;
		cmd_valid_i && port_byte_i == 8'hCD && !pcm_port_mode_i ##[1:2] rd_req_i && !cmd_valid_i;
	endsequence
	// Outputs lag the shadow by one edge, so wait for it to settle
	sequence s_steady;
		strobe_mode_select_i && $past(strobe_mode_select_i) && $stable(cfg_reg) && $past(cfg_reg, 2) == cfg_reg;
	endsequence
	AST_RD_CAUSE: assert property (rd_valid_o |-> $past(rd_req_i))
		else $error("read byte without a request");
	AST_CFG_READ: assert property (s_cfg_read |=> rd_valid_o && rd_data_o == cfg_reg)
		else $error("configuration read mismatch");
	AST_CD_REFUSED: assert property (s_cd_refused |=> !rd_valid_o)
		else $error("sample readback outside port mode");
	AST_NO_STROBE: assert property (!strobe_mode_select_i && !$past(strobe_mode_select_i) |-> !strobe_output_o)
		else $error("strobe with mode select low");
	AST_STB_LEVEL: assert property (s_steady ##0 !cfg_reg[7] |-> strobe_output_o == cfg_reg[6])
		else $error("strobe not at idle level");
	AST_STB_PULSE: assert property (s_steady ##0 (cfg_reg[7] && strobe_output_o != cfg_reg[6]) |=> strobe_output_o == cfg_reg[6])
		else $error("strobe pulse longer than one cycle");
	AST_CHOP_OFF: assert property (!cfg_reg[0] && $stable(cfg_reg) && $past(cfg_reg, 2) == cfg_reg |-> !chopper_clock_out_o)
		else $error("chopper clock while disabled");
	AST_HOOK_VAL: assert property (((hook_status_o ^ $past(hook_status_o)) & (hook_status_o ^ $past(hook_input_bit_i))) == 4'h0)
		else $error("hook status moved away from input");
	AST_HOOK_MIN: assert property (cfg_reg[5:2] >= 4'h2 && hook_input_bit_i != $past(hook_input_bit_i) |=> $stable(hook_status_o)[*8])
		else $error("hook status changed too early");
endmodule

bind ccd_top ccd_checker chk (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i),
	.data_valid_i(data_valid_i), .port_byte_i(port_byte_i), .rd_req_i(rd_req_i), .rd_valid_o(rd_valid_o),
	.rd_data_o(rd_data_o), .pcm_port_mode_i(pcm_port_mode_i), .hook_input_bit_i(hook_input_bit_i),
	.hook_status_o(hook_status_o), .strobe_mode_select_i(strobe_mode_select_i),
	.strobe_output_o(strobe_output_o), .chopper_clock_out_o(chopper_clock_out_o));

// [tb/ccd_host_model.sv]
// Host model of the control port: command, data and read strobes.
// Assumes the block samples strobes on rising edges of ref_clk_i.
`timescale 1ns/1ps
module ccd_host_model (
	input wire logic ref_clk_i,
	output logic cmd_valid_o,
	output logic data_valid_o,
	output logic [7:0] port_byte_o,
	output logic rd_req_o,
	input wire logic rd_valid_i,
	input wire logic [7:0] rd_data_i
);
	initial begin
		cmd_valid_o = 1'b0;
		data_valid_o = 1'b0;
		rd_req_o = 1'b0;
		port_byte_o = 8'h00;
	end

	// One-cycle strobe; byte inverted afterwards so a stale value never passes
	task automatic strobe(input logic is_cmd, input logic [7:0] b);
		@(posedge ref_clk_i);
		#1;
		cmd_valid_o = is_cmd;
		data_valid_o = !is_cmd;
		port_byte_o = b;
		@(posedge ref_clk_i);
		#1;
		cmd_valid_o = 1'b0;
		data_valid_o = 1'b0;
		port_byte_o = ~b;
	endtask

	// Read request held to its sampling edge, answer taken within four edges
	task automatic read_byte(output logic ok, output logic [7:0] b);
		ok = 1'b0;
		b = 8'h00;
		@(posedge ref_clk_i);
		#1;
		rd_req_o = 1'b1;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(posedge ref_clk_i);
			#1;
			rd_req_o = 1'b0;
			if (rd_valid_i === 1'b1) begin
				ok = 1'b1;
				b = rd_data_i;
			end
		end
	endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for ccd_top with shortened sample and ms counts.
// Assumes ccd_host_model drives the command port and ccd_checker is bound.
`timescale 1ns/1ps
`include "ccd_consts.svh"
module testbench;
	typedef struct {logic [7:0] cmd; int n; logic [79:0] data; logic [7:0] ocmd; int olen; logic [79:0] oexp;} ccd_row_s;
	localparam int SC = 20;
	logic clk, rstn, cmd_v, dat_v, rdq, rdv, pcm, comp, smode, stb, hwy, chop;
	logic [7:0] pbyte, rdd, csamp;
	logic signed [15:0] lsamp, zin, zout;
	logic [3:0] hin, hst;
	logic [79:0] acc;
	logic ok;
	logic [7:0] b;
	int c;
	int miscompares = 0;
	int tests_run = 0;
	ccd_row_s rows [3] = '{'{8'h98, 10, 80'h1234_5678_9ABC_DEF0_1357, 8'h9B, 5, 80'(`CCD_IIR_RST)},
		'{8'h9A, 5, 80'hA1_B2C3_D4E5, 8'h99, 10, 80'h1234_5678_9ABC_DEF0_1357},
		'{8'hC8, 1, 80'hC1, 8'h9B, 5, 80'hA1_B2C3_D4E5}};

	ccd_top #(.SAMPLE_CYC(SC), .MS_CYC(50)) dut (.ref_clk_i(clk), .resetn_i(rstn), .cmd_valid_i(cmd_v),
		.data_valid_i(dat_v), .port_byte_i(pbyte), .rd_req_i(rdq), .rd_valid_o(rdv), .rd_data_o(rdd),
		.pcm_port_mode_i(pcm), .companded_mode_i(comp), .compressed_sample_i(csamp), .linear_sample_i(lsamp),
		.zfilt_in_i(zin), .zfilt_out_o(zout), .hook_input_bit_i(hin), .hook_status_o(hst),
		.strobe_mode_select_i(smode), .strobe_output_o(stb), .highway_clk_o(hwy), .chopper_clock_out_o(chop));
	ccd_host_model host (.ref_clk_i(clk), .cmd_valid_o(cmd_v), .data_valid_o(dat_v), .port_byte_o(pbyte),
		.rd_req_o(rdq), .rd_valid_i(rdv), .rd_data_i(rdd));

	// ----------------------------------------------------------------
	// Clock and helpers
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic cmp(input string what, input logic [79:0] exp, input logic [79:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Bytes go out most significant first, as the host pairs them
	task automatic wr(input logic [7:0] cm, input int n, input logic [79:0] d);
		host.strobe(1'b1, cm);
		for (int k = 0; k < n; k++) host.strobe(1'b0, d[8*(n-1-k)+:8]);
	endtask
	// A missing answer shows up as unknown bytes and so always miscompares
	task automatic chk_rd(input string what, input logic [7:0] cm, input int n, input logic [79:0] exp);
		acc = '0;
		host.strobe(1'b1, cm);
		for (int k = 0; k < n; k++) begin
			host.read_byte(ok, b);
			acc = {acc[71:0], ok ? b : 8'hxx};
		end
		cmp(what, exp, acc);
	endtask
	// Cycles between two toggles, bounded so a dead clock cannot hang the run
	task automatic half_period(input logic sel, output int cyc);
		logic v;
		for (int j = 0; j < 2; j++) begin
			v = sel ? chop : hwy;
			cyc = 0;
			while ((sel ? chop : hwy) === v && cyc < 1000) begin
				@(posedge clk);
				#1;
				cyc++;
			end
		end
	endtask
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{rstn, pcm, comp, smode, csamp, lsamp, zin, hin} = '0;
		repeat (2) @(posedge clk);
		#1;
		rstn = 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].cmd, rows[i].n, rows[i].data);
			chk_rd("own readback", rows[i].cmd | 8'h01, rows[i].n, rows[i].data);
			chk_rd("other set", rows[i].ocmd, rows[i].olen, rows[i].oexp);
		end
		// Aborted coefficient write leaves the old set in place
		host.strobe(1'b1, 8'h98);
		host.strobe(1'b0, 8'h55);
		chk_rd("fir after abort", 8'h99, 10, rows[0].data);
		half_period(1'b0, c);
		cmp("highway half period", 80'(`CCD_HWY_HALF_CYC), 80'(c));
		half_period(1'b1, c);
		cmp("chopper half period", 80'(`CCD_CHOP_HALF_CYC), 80'(c));
		wr(8'hC8, 1, 80'h02);
		half_period(1'b0, c);
		cmp("double highway half", 80'(`CCD_HWY_HALF_CYC / 2), 80'(c));
		cmp("chopper off", 80'h0, {79'h0, chop});
		smode = 1'b1;
		wr(8'hC8, 1, 80'h40);
		repeat (3) @(posedge clk);
		#1;
		cmp("strobe idle low-going", 80'h1, {79'h0, stb});
		wr(8'hC8, 1, 80'hC0);
		c = 0;
		repeat (2 * SC) begin
			@(posedge clk);
			#1;
			c += (stb === 1'b0);
		end
		cmp("strobe pulses", 80'h2, 80'(c));
		smode = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		cmp("strobe mode off", 80'h0, {79'h0, stb});
		// Transmit readback, second byte reserved and not compared
		{pcm, comp, csamp, lsamp} = {2'b11, 8'h5A, 16'hC321};
		chk_rd("companded sample", 8'hCD, 1, 80'h5A);
		host.read_byte(ok, b);
		comp = 1'b0;
		chk_rd("linear upper byte", 8'hCD, 1, 80'hC3);
		host.read_byte(ok, b);
		pcm = 1'b0;
		host.strobe(1'b1, 8'hCD);
		host.read_byte(ok, b);
		cmp("readback refused", 80'h0, {79'h0, ok});
		// Filter with z0 of plus and minus one, recursion cleared
		zin = 16'sd1000;
		wr(8'h9A, 5, 80'(`CCD_IIR_RST));
		wr(8'h98, 10, 80'h0111_0190_0190_0190_0190);
		repeat (4 * SC) @(posedge clk);
		#1;
		cmp("filter unit tap", 80'h03E8, {64'h0, zout});
		wr(8'h98, 10, 80'h0119_0190_0190_0190_0190);
		repeat (4 * SC) @(posedge clk);
		#1;
		cmp("filter negative tap", 80'hFC18, {64'h0, zout});
		// z5 = 1, z6 = 1, z7 = 0.5: recursion settles at 999 in Q16, plus z0 of minus one
		wr(8'h9A, 5, 80'h01_1101_0112);
		repeat (20 * SC) @(posedge clk);
		#1;
		cmp("filter recursion", 80'hFFFF, {64'h0, zout});
		wr(8'hC8, 1, 80'h04);
		hin = 4'hF;
		for (int i = 0; i < 400 && hst !== 4'hF; i++) begin
			@(posedge clk);
			#1;
		end
		cmp("hook status all", 80'hF, {76'h0, hst});
		// Second reset; hook inputs rise as it ends, so the minimum hold is watched
		rstn = 1'b0;
		hin = 4'h0;
		repeat (2) @(posedge clk);
		#1;
		rstn = 1'b1;
		hin = 4'hF;
		cmp("hook after reset", 80'h0, {76'h0, hst});
		chk_rd("fir reset", 8'h99, 10, `CCD_FIR_RST);
		chk_rd("iir reset", 8'h9B, 5, 80'(`CCD_IIR_RST));
		chk_rd("cfg reset", 8'hC9, 1, 80'h20);
		cmp("filter reset output", 80'h0, {64'h0, zout});
		repeat (180) @(posedge clk);
		#1;
		cmp("hook before 8 ms", 80'h0, {76'h0, hst});
		for (int i = 0; i < 400 && hst !== 4'hF; i++) begin
			@(posedge clk);
			#1;
		end
		cmp("hook after 8 ms", 80'hF, {76'h0, hst});
		tally_and_finish();
	end
endmodule
